//--- rtl/gsc_global_switch_control.sv
// Global switch control register and the control decisions it drives.
// Assumes config requests, preload and port status are synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module gsc_global_switch_control
	import gsc_pkg::*;
#(
	parameter int NUM_DS = 3,
	parameter int PME_WIDTH = 5
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic fundamental_reset_input_b,
	input wire gsc_cfg_req_type cfg_req,
	output gsc_cfg_rsp_type cfg_rsp,
	input wire gsc_preload_type preload,
	input wire logic upstream_rx_in_l0s,
	input wire logic [NUM_DS-1:0] ds_tx_l0s_want,
	input wire logic upstream_ds_packet_rx,
	input wire logic [NUM_DS-1:0] slot_power_switch_control_off,
	output logic [NUM_DS-1:0] ds_tx_l0s_allow,
	output logic ds_wake_all,
	output logic capability_sleep_state_flag,
	output logic [PME_WIDTH-1:0] pme_state_support_mask,
	output logic [NUM_DS-1:0] ds_pme_turn_off_req,
	output logic [NUM_DS-1:0] ds_beacon_detect_enable,
	output logic ref_low_power_allow
);
	// ************************************************************
	// Register storage
	// ************************************************************
	logic downstream_lowpower_independence;
	logic defer_wakeup;
	logic intermediate_sleep_capable;
	logic slot_power_off_message_enable;
	logic wake_signal_detect_disable;
	logic [NUM_DS-1:0] slot_off_q;
	logic [15:0] reg_value;
	logic [15:0] wmask;
	logic hit;
	logic do_wr;
	logic do_rd;

	assign hit = (cfg_req.addr == GSC_OFFSET);
	assign do_rd = cfg_req.rd && hit;
	assign do_wr = cfg_req.wr && hit;
	assign wmask = {{8{cfg_req.be[1]}}, {8{cfg_req.be[0]}}} & GSC_WRITE_MASK;

	// Global reset domain field
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			wake_signal_detect_disable <= GSC_RESET[GSC_BIT_WAKE];
		end else if (preload.valid) begin
			wake_signal_detect_disable <= preload.data[GSC_BIT_WAKE];
		end else if (do_wr && wmask[GSC_BIT_WAKE]) begin
			wake_signal_detect_disable <= cfg_req.wdata[GSC_BIT_WAKE];
		end
	end

	// Fundamental reset domain fields
	always_ff @(posedge sys_clk) begin
		if (!rst_b || !fundamental_reset_input_b) begin
			defer_wakeup <= GSC_RESET[GSC_BIT_DEFER];
			intermediate_sleep_capable <= GSC_RESET[GSC_BIT_SLEEP];
			slot_power_off_message_enable <= GSC_RESET[GSC_BIT_MSG];
		end else if (preload.valid) begin
			defer_wakeup <= preload.data[GSC_BIT_DEFER];
			intermediate_sleep_capable <= preload.data[GSC_BIT_SLEEP];
			slot_power_off_message_enable <= preload.data[GSC_BIT_MSG];
		end else if (do_wr) begin
			if (wmask[GSC_BIT_DEFER]) defer_wakeup <= cfg_req.wdata[GSC_BIT_DEFER];
			if (wmask[GSC_BIT_SLEEP]) intermediate_sleep_capable <= cfg_req.wdata[GSC_BIT_SLEEP];
			if (wmask[GSC_BIT_MSG]) slot_power_off_message_enable <= cfg_req.wdata[GSC_BIT_MSG];
		end
	end

	// Independence bit, not preloaded
	always_ff @(posedge sys_clk) begin
		if (!rst_b || !fundamental_reset_input_b) begin
			downstream_lowpower_independence <= GSC_RESET[GSC_BIT_INDEP];
		end else if (do_wr && wmask[GSC_BIT_INDEP]) begin
			downstream_lowpower_independence <= cfg_req.wdata[GSC_BIT_INDEP];
		end
	end

	// ************************************************************
	// Read path
	// ************************************************************
	always_comb begin
		reg_value = 16'h0000;
		reg_value[GSC_BIT_INDEP] = downstream_lowpower_independence;
		reg_value[GSC_BIT_DEFER] = defer_wakeup;
		reg_value[GSC_BIT_SLEEP] = intermediate_sleep_capable;
		reg_value[GSC_BIT_MSG] = slot_power_off_message_enable;
		reg_value[GSC_BIT_WAKE] = wake_signal_detect_disable;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			cfg_rsp <= '0;
		end else begin
			cfg_rsp.hit <= do_rd;
			cfg_rsp.rdata <= do_rd ? reg_value : 16'h0000;
		end
	end

	// ************************************************************
	// Control outputs
	// ************************************************************
	logic [NUM_DS-1:0] next_l0s_allow;
	logic [NUM_DS-1:0] slot_off_edge;
	assign slot_off_edge = slot_power_switch_control_off & ~slot_off_q;
	assign next_l0s_allow = downstream_lowpower_independence ? ds_tx_l0s_want
		: (ds_tx_l0s_want & {NUM_DS{upstream_rx_in_l0s}});

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			slot_off_q <= '0;
			ds_tx_l0s_allow <= '0;
			ds_wake_all <= 1'b0;
			capability_sleep_state_flag <= 1'b0;
			pme_state_support_mask <= '0;
			ds_pme_turn_off_req <= '0;
			ds_beacon_detect_enable <= '0;
			ref_low_power_allow <= 1'b0;
		end else begin
			slot_off_q <= slot_power_switch_control_off;
			ds_tx_l0s_allow <= next_l0s_allow;
			ds_wake_all <= upstream_ds_packet_rx && !defer_wakeup;
			capability_sleep_state_flag <= intermediate_sleep_capable;
			pme_state_support_mask <= PME_WIDTH'(intermediate_sleep_capable) << GSC_PME_SLEEP_BIT;
			ds_pme_turn_off_req <= slot_off_edge & {NUM_DS{slot_power_off_message_enable}};
			ds_beacon_detect_enable <= {NUM_DS{!wake_signal_detect_disable}};
			ref_low_power_allow <= wake_signal_detect_disable;
		end
	end
endmodule : gsc_global_switch_control
`default_nettype wire

//--- rtl/gsc_pkg.sv
// Package for the global switch control register block.
// Assumes a 16-bit configuration access port with two byte enables.
package gsc_pkg;
	// ************************************************************
	// Register map
	// ************************************************************
	localparam logic [11:0] GSC_OFFSET = 12'h0EA;
	localparam logic [15:0] GSC_RESET = 16'h0004;
	localparam logic [15:0] GSC_WRITE_MASK = 16'h0057;
	localparam int GSC_BIT_INDEP = 6;
	localparam int GSC_BIT_DEFER = 4;
	localparam int GSC_BIT_SLEEP = 2;
	localparam int GSC_BIT_MSG = 1;
	localparam int GSC_BIT_WAKE = 0;
	localparam int GSC_PME_SLEEP_BIT = 1;

	// ************************************************************
	// Carriers
	// ************************************************************
	typedef struct packed {
		logic wr;
		logic rd;
		logic [11:0] addr;
		logic [1:0] be;
		logic [15:0] wdata;
	} gsc_cfg_req_type;

	typedef struct packed {
		logic [15:0] rdata;
		logic hit;
	} gsc_cfg_rsp_type;

	typedef struct packed {
		logic valid;
		logic [15:0] data;
	} gsc_preload_type;
endpackage : gsc_pkg

//--- tb/global_switch_control_reg_test.sv
// Bench for the global switch control register block.
// Assumes the checker is bound in; runs standalone.
`timescale 1ns/1ps
`default_nettype none
module global_switch_control_reg_test import gsc_pkg::*;;
	logic sys_clk = 0, rst_b = 0, frst_b = 1, up = 0, pkt = 0, wake, cap, lp;
	logic [2:0] want = 0, off = 0, allow, toff, bcn;
	logic [4:0] pme;
	gsc_cfg_req_type req = '0;
	gsc_cfg_rsp_type rsp;
	gsc_preload_type pre = '0;
	int err_count = 0, n_compared = 0;
	logic [33:0] rows [5] = '{{2'h1, 16'hFFFF, 16'h0057}, {2'h2, 16'hFFFF, 16'h0057},
		{2'h1, 16'h0000, 16'h0000}, {2'h0, 16'hFFFF, 16'h0000}, {2'h1, 16'h0055, 16'h0055}};
	gsc_global_switch_control u_dut (.sys_clk(sys_clk), .rst_b(rst_b),
		.fundamental_reset_input_b(frst_b), .cfg_req(req), .cfg_rsp(rsp), .preload(pre),
		.upstream_rx_in_l0s(up), .ds_tx_l0s_want(want), .upstream_ds_packet_rx(pkt),
		.slot_power_switch_control_off(off), .ds_tx_l0s_allow(allow), .ds_wake_all(wake),
		.capability_sleep_state_flag(cap), .pme_state_support_mask(pme),
		.ds_pme_turn_off_req(toff), .ds_beacon_detect_enable(bcn), .ref_low_power_allow(lp));
	task cyc; @(posedge sys_clk); #1; endtask : cyc
	task chk(input logic [15:0] s, input logic [15:0] e);
		n_compared++;
		if (s !== e) begin
			err_count++;
			$display("ERROR %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task wr(input logic [1:0] be, input logic [15:0] d);
		req = '{1'b1, 1'b0, GSC_OFFSET, be, d};
		cyc();
	endtask : wr
	task rd(input logic [11:0] a, input logic [15:0] e);
		req = '{1'b0, 1'b1, a, 2'h3, 16'h0000};
		cyc();
		chk(rsp.rdata, e);
		chk(16'(rsp.hit), 16'(a == GSC_OFFSET));
	endtask : rd
	task look(input logic [2:0] t, input logic [15:0] e);
		cyc();
		chk(16'(toff), 16'(t));
		chk(16'({allow, wake, cap, pme, bcn, lp}), e);
	endtask : look
	task conclude;
		$display("compared %0d errors %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : conclude
	initial forever #5 sys_clk = ~sys_clk;
	initial begin
		#100000;
		err_count++;
		conclude();
	end
	initial begin
		cyc();
		cyc();
		rst_b = 1;
		rd(GSC_OFFSET, 16'h0004);
		foreach (rows[i]) begin
			wr(rows[i][33:32], rows[i][31:16]);
			rd(GSC_OFFSET, rows[i][15:0]);
		end
		rd(12'h0E8, 16'h0000);
		want = 3'h5;
		pkt = 1;
		off = 3'h7;
		look(3'h0, 16'h2A21);
		off = 3'h0;
		wr(2'h1, 16'h0002);
		off = 3'h7;
		look(3'h7, 16'h040E);
		wr(2'h1, 16'h0057);
		frst_b = 0;
		cyc();
		frst_b = 1;
		rd(GSC_OFFSET, 16'h0005);
		pre = '{1'b1, 16'hFFFF};
		wr(2'h1, 16'h0000);
		pre = '0;
		up = 1;
		rd(GSC_OFFSET, 16'h0017);
		rst_b = 0;
		cyc();
		rst_b = 1;
		rd(GSC_OFFSET, 16'h0004);
		conclude();
	end
endmodule : global_switch_control_reg_test
`default_nettype wire

//--- tb/gsc_global_switch_control_sva.sv
// Checker for the global switch control register block.
// Assumes binding to the top module, one clock, sync active-low reset.
`timescale 1ns/1ps
`default_nettype none
module gsc_global_switch_control_sva
	import gsc_pkg::*;
#(
	parameter int NUM_DS = 3,
	parameter int PME_WIDTH = 5
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire gsc_cfg_req_type cfg_req,
	input wire gsc_cfg_rsp_type cfg_rsp,
	input wire logic upstream_rx_in_l0s,
	input wire logic [NUM_DS-1:0] ds_tx_l0s_want,
	input wire logic upstream_ds_packet_rx,
	input wire logic [NUM_DS-1:0] slot_power_switch_control_off,
	input wire logic [NUM_DS-1:0] ds_tx_l0s_allow,
	input wire logic ds_wake_all,
	input wire logic capability_sleep_state_flag,
	input wire logic [PME_WIDTH-1:0] pme_state_support_mask,
	input wire logic [NUM_DS-1:0] ds_pme_turn_off_req,
	input wire logic [NUM_DS-1:0] ds_beacon_detect_enable,
	input wire logic ref_low_power_allow
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	sequence s_read;
		cfg_req.rd && cfg_req.addr == GSC_OFFSET;
	endsequence
	a_read_hit: assert property (s_read |=> cfg_rsp.hit) else $error("read not answered");
	a_stray_hit: assert property (!(cfg_req.rd && cfg_req.addr == GSC_OFFSET) |=> !cfg_rsp.hit)
		else $error("unexpected hit");
	a_reserved_zero: assert property ((cfg_rsp.rdata & 16'hFFA8) == 16'h0000)
		else $error("reserved bit set");
	a_idle_rdata: assert property (!cfg_rsp.hit |-> cfg_rsp.rdata == 16'h0000) else $error("rdata");
	a_l0s_follow: assert property (upstream_rx_in_l0s |=> ds_tx_l0s_allow == $past(ds_tx_l0s_want))
		else $error("allow");
	a_l0s_subset: assert property ((ds_tx_l0s_allow & ~$past(ds_tx_l0s_want)) == '0)
		else $error("allow without want");
	a_wake_cause: assert property (ds_wake_all |-> $past(upstream_ds_packet_rx)) else $error("wake");
	a_beacon_pair: assert property ($past(rst_b) |->
		ds_beacon_detect_enable == {NUM_DS{~ref_low_power_allow}}) else $error("beacon");
	a_pme_mirror: assert property (pme_state_support_mask ==
		(PME_WIDTH'(capability_sleep_state_flag) << 1)) else $error("pme mask");
	a_turn_off_edge: assert property ((ds_pme_turn_off_req & ~($past(slot_power_switch_control_off) &
		~$past(slot_power_switch_control_off, 2))) == '0) else $error("turn off");
endmodule : gsc_global_switch_control_sva
bind gsc_global_switch_control gsc_global_switch_control_sva #(.NUM_DS(NUM_DS),
	.PME_WIDTH(PME_WIDTH)) u_sva (.*);
`default_nettype wire
